// >>> verilog/pcfp_pkg.sv
// Constants for the pack current fault protector: offsets, fields, resets, scaling.
// Assumes one 40 MHz clock and a host that writes settings over AXI4-Lite.
// What this block does
// - Rail below lower limit: all gates off, regulator and bias outputs disabled.
// - Rail above start threshold after start-up: enter normal operating mode.
// - Charge gate defaults on if zero-volt select tied to pack, else off.
// - Overload threshold 50..205 mV, 5 mV steps, reset 50 mV, 10 mV hysteresis.
// - Short thresholds 100..475 mV, 25 mV steps, reset 100 mV, 50 mV hysteresis.
// - Overload delay 1..31 ms in 2 ms steps, reset 1 ms.
// - Short delay 0..915 us in 61 us steps, reset zero.
// - Overload detection acts on discharge current only.
// - Short detection both directions, each with its own threshold and delay.
// - Condition must persist the full blanking delay before gates go off.
// - A confirmed overload or short fault switches the gate drives off.
// - Status bits 0..2: short charge, short discharge, overload.
// - A fault sets its status bit and asserts the active-low alert.
// - Fault stays latched until host writes control bit 0 high then low.
// - Fault still present after clear is detected again and protection re-entered.
// - Host tick input times both delays.
// - Alert is open-drain, active low, signalling status register changes.
// - Sleep input high or floating puts the device in sleep mode.
// - Host gate bits act only when protection permits; faults override them.
// - Sleep holds gates off, disables detection, keeps register settings.
`default_nettype none

package pcfp_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_STATUS = 8'h00;
   localparam logic [7:0] OFF_CTL = 8'h04;
   localparam logic [7:0] OFF_OL_TH = 8'h08;
   localparam logic [7:0] OFF_OL_DLY = 8'h0C;
   localparam logic [7:0] OFF_SHORT_CHG = 8'h10;
   localparam logic [7:0] OFF_SHORT_DSG = 8'h14;

   // Control register bits
   localparam int CTL_CLR = 0;
   localparam int CTL_DSG = 1;
   localparam int CTL_CHG = 2;
   localparam int CTL_PRE = 3;
   localparam int CTL_TBIAS = 4;

   // Status register bits
   localparam int ST_SHORT_CHG = 0;
   localparam int ST_SHORT_DSG = 1;
   localparam int ST_OVERLOAD = 2;
   localparam int ST_SLEEP_CHG = 3;
   localparam int ST_SLEEP = 4;
   localparam int ST_NORMAL = 5;
   localparam int ST_GATE = 6;

   // Reset values
   localparam logic [4:0] CTL_RST = 5'h00;
   localparam logic [4:0] OL_TH_RST = 5'h00;
   localparam logic [3:0] OL_DLY_RST = 4'h0;
   localparam logic [7:0] SHORT_RST = 8'h00;
   localparam logic [7:0] PIN_RST = 8'h20;

   // Threshold scaling in mV
   localparam int OL_BASE_MV = 50;
   localparam int OL_STEP_MV = 5;
   localparam int OL_HYST_MV = 10;
   localparam int SHORT_BASE_MV = 100;
   localparam int SHORT_STEP_MV = 25;
   localparam int SHORT_HYST_MV = 50;

   // Delay scaling
   localparam int OL_DLY_BASE_MS = 1;
   localparam int OL_DLY_STEP_MS = 2;
   localparam int SHORT_DLY_BASE_STEPS = 0;
   localparam int SHORT_DLY_STEP_US = 61;

   // Pin vector positions
   localparam int PIN_SHORT_CHG = 0;
   localparam int PIN_SHORT_DSG = 1;
   localparam int PIN_OVERLOAD = 2;
   localparam int PIN_TICK = 3;
   localparam int PIN_ZV_SEL = 4;
   localparam int PIN_SLEEP = 5;
   localparam int PIN_RAIL_LOW = 6;
   localparam int PIN_RAIL_START = 7;
   localparam int NPIN = 8;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic {PWR_OFF, PWR_NORMAL} pcfp_pwr_t;

endpackage

`default_nettype wire

// >>> verilog/pcfp_top.sv
// Pack current fault protector: AXI4-Lite slave, supply and sleep gating,
// fault blanking and latch, gate drives, alert.
// All comparator, monitor, sleep, select and tick inputs are asynchronous.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none

module pcfp_top
   import pcfp_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int OL_TICKS_PER_MS = 16,
   parameter int SHORT_TICKS_PER_STEP = 1
) (
   input wire logic aclk, // 40 MHz clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [ADDR_W-1:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [ADDR_W-1:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic overload_cmp, // Discharge overload comparator
   input wire logic short_charge_cmp, // Charge-direction short comparator
   input wire logic short_discharge_cmp, // Discharge-direction short comparator
   input wire logic watchdog_tick_input, // Host tick, delay time base
   input wire logic zero_volt_charge_select, // High when tied to pack
   input wire logic sleep_pin, // Sleep request, high or floating
   input wire logic rail_below_low, // Supply monitor: rail under low limit
   input wire logic rail_above_start, // Supply monitor: rail over start level
   output logic charge_fet_gate, // Charge gate drive
   output logic discharge_fet_gate, // Discharge gate drive
   output logic precharge_fet_gate, // Precharge gate drive
   output logic alert_n_output, // Open-drain alert level, always low
   output logic alert_n_output_oe, // Alert pulls low while high
   output logic regulator_enable, // Regulator output enable
   output logic thermistor_bias, // Thermistor bias enable
   output logic [8:0] overload_threshold_mv, // Overload reference to comparator
   output logic [8:0] short_charge_threshold_mv, // Charge short reference
   output logic [8:0] short_discharge_threshold_mv // Discharge short reference
);

   function automatic logic [3:0] reg_decode(input logic [ADDR_W-1:0] a);
      logic [7:0] b;
      b = 8'(a);
      case (b)
         OFF_STATUS: reg_decode = 4'h8;
         OFF_CTL: reg_decode = 4'h9;
         OFF_OL_TH: reg_decode = 4'hA;
         OFF_OL_DLY: reg_decode = 4'hB;
         OFF_SHORT_CHG: reg_decode = 4'hC;
         OFF_SHORT_DSG: reg_decode = 4'hD;
         default: reg_decode = 4'h0;
      endcase
   endfunction

   function automatic logic [8:0] thr_mv(input int base, input int step, input int hyst,
                                         input logic [4:0] code, input logic hys_on);
      int v;
      v = base + step * int'(code) - (hys_on ? hyst : 0);
      return v[8:0];
   endfunction

   function automatic logic [15:0] dly_ticks(input int base, input int step,
                                             input int scale, input logic [3:0] code);
      int v;
      v = (base + step * int'(code)) * scale;
      return v[15:0];
   endfunction

   // Pin synchronisers
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] sync1_q;
   logic [NPIN-1:0] sync2_q;

   assign pin_raw[PIN_SHORT_CHG] = short_charge_cmp;
   assign pin_raw[PIN_SHORT_DSG] = short_discharge_cmp;
   assign pin_raw[PIN_OVERLOAD] = overload_cmp;
   assign pin_raw[PIN_TICK] = watchdog_tick_input;
   assign pin_raw[PIN_ZV_SEL] = zero_volt_charge_select;
   assign pin_raw[PIN_SLEEP] = sleep_pin;
   assign pin_raw[PIN_RAIL_LOW] = rail_below_low;
   assign pin_raw[PIN_RAIL_START] = rail_above_start;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_q <= PIN_RST;
         sync2_q <= PIN_RST;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
      end
   end

   // Configuration and state registers
   logic [4:0] ctl_q;
   logic [4:0] ol_th_q;
   logic [3:0] ol_dly_q;
   logic [7:0] short_chg_q;
   logic [7:0] short_dsg_q;
   logic clr_prev_q;
   logic tick_prev_q;
   logic sleep_prev_q;
   logic [3:0] stat_q;
   logic [3:0] stat_d;
   pcfp_pwr_t pwr_q;
   pcfp_pwr_t pwr_d;
   logic [2:0] gate_q;
   logic [2:0] gate_d;
   logic alert_q;
   logic reg_en_q;
   logic tbias_q;
   logic [8:0] thr_q [3];
   logic [8:0] thr_d [3];

   // Bus registers
   logic aw_full_q;
   logic w_full_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [7:0] wdata_q;
   logic wstrb0_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   wire sleeping = sync2_q[PIN_SLEEP];
   wire normal = (pwr_q == PWR_NORMAL);
   wire active = normal & ~sleeping;
   wire tick = sync2_q[PIN_TICK] & ~tick_prev_q;
   wire sleep_edge = sleeping ^ sleep_prev_q;
   wire clr = clr_prev_q & ~ctl_q[CTL_CLR];

   // Power state
   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_OFF: if (sync2_q[PIN_RAIL_START] && !sync2_q[PIN_RAIL_LOW]) pwr_d = PWR_NORMAL;
         PWR_NORMAL: if (sync2_q[PIN_RAIL_LOW]) pwr_d = PWR_OFF;
         default: pwr_d = PWR_OFF;
      endcase
   end

   // Blanking detectors: index follows status bit order
   logic [2:0] cmp;
   logic [2:0] cond;
   logic [2:0] trip;
   logic [15:0] limit [3];
   logic [15:0] cnt_q [3];

   // Overload uses the discharge comparator only
   assign cmp = {sync2_q[PIN_OVERLOAD], sync2_q[PIN_SHORT_DSG], sync2_q[PIN_SHORT_CHG]};
   assign limit[ST_OVERLOAD] =
      dly_ticks(OL_DLY_BASE_MS, OL_DLY_STEP_MS, OL_TICKS_PER_MS, ol_dly_q);
   assign limit[ST_SHORT_CHG] =
      dly_ticks(SHORT_DLY_BASE_STEPS, 1, SHORT_TICKS_PER_STEP, short_chg_q[7:4]);
   assign limit[ST_SHORT_DSG] =
      dly_ticks(SHORT_DLY_BASE_STEPS, 1, SHORT_TICKS_PER_STEP, short_dsg_q[7:4]);

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_det
         assign cond[gi] = cmp[gi] & active;
         assign trip[gi] = cond[gi] & (cnt_q[gi] >= limit[gi]);
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_q[gi] <= 16'h0000;
            end else if (!cond[gi]) begin
               cnt_q[gi] <= 16'h0000;
            end else if (tick && !trip[gi]) begin
               cnt_q[gi] <= cnt_q[gi] + 16'h0001;
            end
         end
      end
   endgenerate

   // Overload and short references, lowered by hysteresis while high
   assign thr_d[ST_OVERLOAD] =
      thr_mv(OL_BASE_MV, OL_STEP_MV, OL_HYST_MV, ol_th_q, cmp[ST_OVERLOAD]);
   assign thr_d[ST_SHORT_CHG] = thr_mv(SHORT_BASE_MV, SHORT_STEP_MV, SHORT_HYST_MV,
                                       {1'b0, short_chg_q[3:0]}, cmp[ST_SHORT_CHG]);
   assign thr_d[ST_SHORT_DSG] = thr_mv(SHORT_BASE_MV, SHORT_STEP_MV, SHORT_HYST_MV,
                                       {1'b0, short_dsg_q[3:0]}, cmp[ST_SHORT_DSG]);

   // Latch faults; a standing trip wins over the clear
   assign stat_d = (stat_q & ~{4{clr}}) | {sleep_edge, trip};

   // Host requests pass only with no fault; off when inactive
   assign gate_d = {ctl_q[CTL_PRE], ctl_q[CTL_CHG], ctl_q[CTL_DSG]} &
                   {3{active & ~(|stat_q[2:0]) & ~(|trip)}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_q <= PWR_OFF;
         stat_q <= 4'h0;
         gate_q <= 3'h0;
         alert_q <= 1'b0;
         reg_en_q <= 1'b0;
         tbias_q <= 1'b0;
         clr_prev_q <= 1'b0;
         tick_prev_q <= 1'b0;
         sleep_prev_q <= 1'b1;
         for (int i = 0; i < 3; i++) begin
            thr_q[i] <= 9'h000;
         end
      end else begin
         pwr_q <= pwr_d;
         stat_q <= stat_d;
         gate_q <= gate_d;
         alert_q <= |stat_d;
         reg_en_q <= (pwr_d == PWR_NORMAL);
         tbias_q <= (pwr_d == PWR_NORMAL) & ctl_q[CTL_TBIAS];
         clr_prev_q <= ctl_q[CTL_CLR];
         tick_prev_q <= sync2_q[PIN_TICK];
         sleep_prev_q <= sleeping;
         thr_q <= thr_d;
      end
   end

   // Write channel
   wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
   wire [3:0] wr_dec = reg_decode(awaddr_q);
   wire wr_hit = do_wr & wr_dec[3] & wstrb0_q;

   assign awready = ~aw_full_q;
   assign wready = ~w_full_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         awaddr_q <= '0;
      end else if (awvalid && !aw_full_q) begin
         aw_full_q <= 1'b1;
         awaddr_q <= awaddr;
      end else if (do_wr) begin
         aw_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full_q <= 1'b0;
         wdata_q <= 8'h00;
         wstrb0_q <= 1'b0;
      end else if (wvalid && !w_full_q) begin
         w_full_q <= 1'b1;
         wdata_q <= wdata[7:0];
         wstrb0_q <= wstrb[0];
      end else if (do_wr) begin
         w_full_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_dec[3] ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign bvalid = bvalid_q;
   assign bresp = bresp_q;

   // Settings survive sleep and power-off, except the charge bit reloaded on entering normal mode; only reset restores them
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_q <= CTL_RST;
         ol_th_q <= OL_TH_RST;
         ol_dly_q <= OL_DLY_RST;
         short_chg_q <= SHORT_RST;
         short_dsg_q <= SHORT_RST;
      end else begin
         if (wr_hit && wr_dec[2:0] == 3'h1) begin
            ctl_q <= wdata_q[4:0];
         end
         // Charge default from zero-volt select on entering normal mode
         if (pwr_q == PWR_OFF && pwr_d == PWR_NORMAL) begin
            ctl_q[CTL_CHG] <= sync2_q[PIN_ZV_SEL];
         end
         if (wr_hit && wr_dec[2:0] == 3'h2) begin
            ol_th_q <= wdata_q[4:0];
         end
         if (wr_hit && wr_dec[2:0] == 3'h3) begin
            ol_dly_q <= wdata_q[3:0];
         end
         if (wr_hit && wr_dec[2:0] == 3'h4) begin
            short_chg_q <= wdata_q;
         end
         if (wr_hit && wr_dec[2:0] == 3'h5) begin
            short_dsg_q <= wdata_q;
         end
      end
   end

   // Read channel
   wire [3:0] rd_dec = reg_decode(araddr);
   logic [31:0] rd_word;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_dec[2:0])
         3'h0: rd_word = {23'h00_0000, gate_q, normal, sleeping, stat_q};
         3'h1: rd_word = {27'h000_0000, ctl_q};
         3'h2: rd_word = {27'h000_0000, ol_th_q};
         3'h3: rd_word = {28'h000_0000, ol_dly_q};
         3'h4: rd_word = {24'h00_0000, short_chg_q};
         3'h5: rd_word = {24'h00_0000, short_dsg_q};
         default: rd_word = 32'h0000_0000;
      endcase
      if (!rd_dec[3]) begin
         rd_word = 32'h0000_0000;
      end
   end

   assign arready = ~rvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= RESP_OKAY;
      end else if (arvalid && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_word;
         rresp_q <= rd_dec[3] ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign rvalid = rvalid_q;
   assign rdata = rdata_q;
   assign rresp = rresp_q;

   // Pin outputs
   assign discharge_fet_gate = gate_q[0];
   assign charge_fet_gate = gate_q[1];
   assign precharge_fet_gate = gate_q[2];
   assign alert_n_output = 1'b0;
   assign alert_n_output_oe = alert_q;
   assign regulator_enable = reg_en_q;
   assign thermistor_bias = tbias_q;
   assign short_charge_threshold_mv = thr_q[ST_SHORT_CHG];
   assign short_discharge_threshold_mv = thr_q[ST_SHORT_DSG];
   assign overload_threshold_mv = thr_q[ST_OVERLOAD];

endmodule // pcfp_top

`default_nettype wire

// >>> verification/pcfp_assertions.sv
// Checker for pcfp_top: gating, alert, references, latch, reads.
// Bound to pcfp_top and sees only its ports.
`default_nettype none
module pcfp_assertions (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Reset, active low
   input wire logic bvalid, // Write answer
   input wire logic arvalid, // Read request
   input wire logic arready, // Read ready
   input wire logic rvalid, // Read answer
   input wire logic sleep_pin, // Sleep pin
   input wire logic rail_below_low, // Rail low
   input wire logic charge_fet_gate, // Charge gate
   input wire logic discharge_fet_gate, // Discharge gate
   input wire logic precharge_fet_gate, // Precharge gate
   input wire logic alert_n_output, // Alert level
   input wire logic alert_n_output_oe, // Alert drive
   input wire logic regulator_enable, // Regulator
   input wire logic thermistor_bias, // Bias
   input wire logic [8:0] overload_threshold_mv, // Reference
   input wire logic [8:0] short_charge_threshold_mv, // Reference
   input wire logic [8:0] short_discharge_threshold_mv // Reference
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   logic gates;
   logic [3:0] wr_age_q;
   assign gates = charge_fet_gate | discharge_fet_gate | precharge_fet_gate;
   // Cycles since last write answer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_age_q <= 4'hF;
      end else if (bvalid) begin
         wr_age_q <= 4'h0;
      end else if (wr_age_q != 4'hF) begin
         wr_age_q <= wr_age_q + 4'h1;
      end
   end
   a_rail_off: assert property (
      rail_below_low [*6] |-> !gates && !regulator_enable && !thermistor_bias)
      else $error("outputs on with rail low");
   a_sleep_off: assert property (
      sleep_pin [*4] |-> !gates) else $error("gate on in sleep");
   a_alert_low: assert property (
      alert_n_output == 1'b0) else $error("alert level not low");
   a_ol_range: assert property (
      $past(aresetn, 2) |-> overload_threshold_mv inside {[40:205]}
      && overload_threshold_mv % 5 == 0) else $error("overload ref off grid");
   a_sc_range: assert property (
      $past(aresetn, 2) |-> short_charge_threshold_mv inside {[50:475]}
      && short_discharge_threshold_mv inside {[50:475]}
      && short_charge_threshold_mv % 25 == 0 && short_discharge_threshold_mv % 25 == 0)
      else $error("short ref off grid");
   a_latch_hold: assert property (
      $fell(alert_n_output_oe) |-> wr_age_q < 4'h6) else $error("alert fell without clear");
   a_gate_cause: assert property (
      $rose(gates) |-> !$past(sleep_pin, 3)) else $error("gate rose during sleep");
   a_read_answer: assert property (
      arvalid && arready |=> rvalid) else $error("read not answered");
endmodule // pcfp_assertions

bind pcfp_top pcfp_assertions i_chk (.aclk, .aresetn, .bvalid, .arvalid, .arready,
   .rvalid, .sleep_pin, .rail_below_low, .charge_fet_gate, .discharge_fet_gate,
   .precharge_fet_gate, .alert_n_output, .alert_n_output_oe, .regulator_enable,
   .thermistor_bias, .overload_threshold_mv, .short_charge_threshold_mv,
   .short_discharge_threshold_mv);
`default_nettype wire

// >>> verification/pcfp_far_model.sv
// Far side: host tick and the three current comparators.
// Sense inputs in mV from the bench; references from the block.
`default_nettype none
module pcfp_far_model #(
   parameter int HALF = 20
) (
   input wire logic aclk, // Clock
   input wire logic [9:0] dsg_mv, // Discharge sense voltage
   input wire logic [9:0] chg_mv, // Charge sense voltage
   input wire logic [8:0] ol_ref, // Overload reference
   input wire logic [8:0] scc_ref, // Charge short reference
   input wire logic [8:0] scd_ref, // Discharge short reference
   output logic tick, // Host tick
   output logic ol_cmp, // Overload comparator
   output logic scc_cmp, // Charge short comparator
   output logic scd_cmp // Discharge short comparator
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt_q = 0;
   logic tick_q = 1'b0;
   always @(posedge aclk) begin
      cnt_q <= (cnt_q == HALF - 1) ? 0 : cnt_q + 1;
      tick_q <= tick_q ^ (cnt_q == HALF - 1);
   end
   assign tick = tick_q;
   assign ol_cmp = dsg_mv > {1'b0, ol_ref};
   assign scd_cmp = dsg_mv > {1'b0, scd_ref};
   assign scc_cmp = chg_mv > {1'b0, scc_ref};
endmodule // pcfp_far_model
`default_nettype wire

// >>> verification/pcfp_tb_top.sv
// Self-checking bench for pcfp_top.
// Assumes an AXI4-Lite slave; waits are bounded.
`default_nettype none
`define CHECK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin failures++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
`define WAITFOR(c, lim) for (n = 0; n < (lim) && (c) !== 1'b1; n++) @(posedge aclk); \
   if ((c) !== 1'b1) begin failures++; print_verdict(); end
module pcfp_tb_top
   import pcfp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TP = 40;
   typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e; logic [1:0] rs;} pcfp_row_t;
   logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp;
   logic overload_cmp, short_charge_cmp, short_discharge_cmp, watchdog_tick_input;
   logic zero_volt_charge_select = 1'b1, sleep_pin = 1'b0;
   logic rail_below_low = 1'b0, rail_above_start = 1'b1;
   logic charge_fet_gate, discharge_fet_gate, precharge_fet_gate, alert_n_output;
   logic alert_n_output_oe, regulator_enable, thermistor_bias;
   logic [8:0] overload_threshold_mv, short_charge_threshold_mv, short_discharge_threshold_mv;
   logic [9:0] dsg_mv = 10'h000, chg_mv = 10'h000;
   int failures = 0, num_checks = 0;
   pcfp_row_t rows [5] = '{
      '{OFF_OL_TH, 32'h0000_00FF, 32'h0000_001F, RESP_OKAY},
      '{OFF_OL_DLY, 32'h0000_0002, 32'h0000_0002, RESP_OKAY},
      '{OFF_SHORT_CHG, 32'h0000_002F, 32'h0000_002F, RESP_OKAY},
      '{OFF_SHORT_DSG, 32'h0000_000F, 32'h0000_000F, RESP_OKAY},
      '{8'h18, 32'h0000_0055, 32'h0000_0000, RESP_SLVERR}};

   always #12.5 aclk = ~aclk;

   pcfp_top #(.OL_TICKS_PER_MS(1), .SHORT_TICKS_PER_STEP(1)) i_dut (
      .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
      .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .overload_cmp, .short_charge_cmp, .short_discharge_cmp,
      .watchdog_tick_input, .zero_volt_charge_select, .sleep_pin, .rail_below_low,
      .rail_above_start, .charge_fet_gate, .discharge_fet_gate, .precharge_fet_gate,
      .alert_n_output, .alert_n_output_oe, .regulator_enable, .thermistor_bias,
      .overload_threshold_mv, .short_charge_threshold_mv, .short_discharge_threshold_mv);

   pcfp_far_model #(.HALF(TP / 2)) i_far (.aclk, .dsg_mv, .chg_mv,
      .ol_ref(overload_threshold_mv), .scc_ref(short_charge_threshold_mv),
      .scd_ref(short_discharge_threshold_mv), .tick(watchdog_tick_input),
      .ol_cmp(overload_cmp), .scc_cmp(short_charge_cmp), .scd_cmp(short_discharge_cmp));

   task automatic print_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         awvalid <= awvalid & ~awready;
         wvalid <= wvalid & ~wready;
         if (bvalid === 1'b1) break;
      end
      rs = bresp;
      bready <= 1'b0;
      if (n == 50) begin
         failures++;
         print_verdict();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge aclk);
         arvalid <= arvalid & ~arready;
         if (rvalid === 1'b1) break;
      end
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 50) begin
         failures++;
         print_verdict();
      end
   endtask

   task automatic clr();
      logic [1:0] rs;
      wr(OFF_CTL, 32'h0000_0017, rs);
      wr(OFF_CTL, 32'h0000_0016, rs);
   endtask

   initial begin
      int n;
      logic [31:0] d;
      logic [1:0] r;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      cyc(10);
      `CHECK("reg_en", 1'b1, regulator_enable)
      `CHECK("chg_gate", 1'b1, charge_fet_gate)
      `CHECK("ol_ref", OL_BASE_MV, overload_threshold_mv)
      `CHECK("scc_ref", SHORT_BASE_MV, short_charge_threshold_mv)
      `CHECK("scd_ref", SHORT_BASE_MV, short_discharge_threshold_mv)
      rd(OFF_OL_DLY, d, r);
      `CHECK("ol_dly", 32'h0000_0000, d)
      rd(OFF_SHORT_DSG, d, r);
      `CHECK("sc_dly", 32'h0000_0000, d)
      rd(OFF_CTL, d, r);
      `CHECK("ctl", 32'h0000_0004, d)
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w, r);
         `CHECK("bresp", rows[i].rs, r)
         rd(rows[i].a, d, r);
         `CHECK("rdata", rows[i].e, d)
         `CHECK("rresp", rows[i].rs, r)
      end
      `CHECK("ol_max", OL_BASE_MV + OL_STEP_MV * 31, overload_threshold_mv)
      `CHECK("scd_max", SHORT_BASE_MV + SHORT_STEP_MV * 15, short_discharge_threshold_mv)
      wr(OFF_CTL, 32'h0000_0016, r);
      chg_mv <= 10'h12C;
      cyc(8 * TP);
      `CHECK("dsg_on", 1'b1, discharge_fet_gate)
      `CHECK("bias", 1'b1, thermistor_bias)
      chg_mv <= 10'h000;
      dsg_mv <= 10'h0DC;
      cyc(10);
      `CHECK("ol_hyst", OL_BASE_MV + OL_STEP_MV * 31 - OL_HYST_MV, overload_threshold_mv)
      cyc(2 * TP - 10);
      dsg_mv <= 10'h000;
      cyc(TP);
      dsg_mv <= 10'h0DC;
      cyc(2 * TP);
      `CHECK("restart", 1'b1, discharge_fet_gate)
      cyc(TP);
      `CHECK("blanking", 1'b1, discharge_fet_gate)
      `WAITFOR(discharge_fet_gate == 1'b0, 4 * TP)
      `CHECK("alert", 1'b1, alert_n_output_oe)
      `CHECK("gates", 1'b0, charge_fet_gate | precharge_fet_gate)
      rd(OFF_STATUS, d, r);
      `CHECK("status", 32'h0000_0004, d & 32'h0000_0007)
      clr();
      cyc(2 * TP);
      `CHECK("retrip", 1'b0, discharge_fet_gate)
      `CHECK("retrip_al", 1'b1, alert_n_output_oe)
      dsg_mv <= 10'h000;
      cyc(10);
      wr(OFF_CTL, 32'h0000_0017, r);
      cyc(10);
      `CHECK("held", 1'b1, alert_n_output_oe)
      wr(OFF_CTL, 32'h0000_0016, r);
      cyc(10);
      `CHECK("cleared", 1'b0, alert_n_output_oe)
      `CHECK("dsg_back", 1'b1, discharge_fet_gate)
      wr(OFF_SHORT_DSG, 32'h0000_0000, r);
      dsg_mv <= 10'h078;
      `WAITFOR(alert_n_output_oe, 8)
      `CHECK("scd_hyst", SHORT_BASE_MV - SHORT_HYST_MV, short_discharge_threshold_mv)
      rd(OFF_STATUS, d, r);
      `CHECK("scd_st", 32'h0000_0002, d & 32'h0000_0007)
      dsg_mv <= 10'h000;
      clr();
      wr(OFF_SHORT_CHG, 32'h0000_0020, r);
      chg_mv <= 10'h096;
      cyc(30);
      `CHECK("scc_wait", 1'b0, alert_n_output_oe)
      `WAITFOR(alert_n_output_oe, 3 * TP)
      rd(OFF_STATUS, d, r);
      `CHECK("scc_st", 32'h0000_0001, d & 32'h0000_0007)
      chg_mv <= 10'h000;
      clr();
      sleep_pin <= 1'b1;
      dsg_mv <= 10'h0DC;
      cyc(8 * TP);
      `CHECK("slp_gates", 1'b0, discharge_fet_gate | charge_fet_gate)
      rd(OFF_STATUS, d, r);
      `CHECK("slp_st", 32'h0000_0010, d & 32'h0000_0017)
      rd(OFF_OL_TH, d, r);
      `CHECK("slp_keep", 32'h0000_001F, d)
      sleep_pin <= 1'b0;
      dsg_mv <= 10'h000;
      cyc(10);
      clr();
      rail_below_low <= 1'b1;
      rail_above_start <= 1'b0;
      cyc(10);
      `CHECK("rail_reg", 1'b0, regulator_enable)
      `CHECK("rail_bias", 1'b0, thermistor_bias)
      `CHECK("rail_gate", 1'b0, discharge_fet_gate)
      zero_volt_charge_select <= 1'b0;
      rail_below_low <= 1'b0;
      rail_above_start <= 1'b1;
      cyc(10);
      `CHECK("zv_off", 1'b0, charge_fet_gate)
      `CHECK("norm", 1'b1, regulator_enable)
      print_verdict();
   end
endmodule // pcfp_tb_top
`default_nettype wire
